// ==== common/app_key_defs.svh ====
// Timing counts, error codes and layout constants of the programming key.
`ifndef APP_KEY_DEFS_SVH
`define APP_KEY_DEFS_SVH

// ==========================================================
// Clock and button timing
`define KEY_CLK_HZ          50000000
`define KEY_CYC_PER_MS      (`KEY_CLK_HZ / 1000)
`define KEY_CONFIRM_HOLD_MS 3000
`define KEY_ERASE_HOLD_MS   15000
`define KEY_BLINK_HALF_MS   125

// ==========================================================
// Indicator sequencing
`define KEY_ERASE_ACK_TICKS 8

// ==========================================================
// Error codes shown on the controller display
`define KEY_ERR_ID_MISMATCH 8'h33
`define KEY_ERR_MEM_FULL    8'h34
`define KEY_ERR_MEM_EMPTY   8'h35
`define KEY_ERR_NONE        8'h00

// ==========================================================
// Store and buffer shape
`define KEY_DATA_WIDTH      8
`define KEY_STORE_DEPTH     1024
`define KEY_FIFO_DEPTH      8
`define KEY_TAG_WIDTH       2

`endif

// ==== common/app_key_pkg.sv ====
// Types shared by the programming key logic.
`default_nettype none

package app_key_pkg;

	// ==========================================================
	// Protection tag carried by an application or a controller
	typedef enum logic [1:0] {
		open_protection_tag   = 2'h0,
		customer_locked_tag   = 2'h1,
		sales_sample_tag      = 2'h2
	} tag_kind_t;

	// ==========================================================
	// Class of each beat on the upload stream
	typedef enum logic [1:0] {
		beat_code       = 2'h0,
		beat_default    = 2'h1,
		beat_live_param = 2'h2,
		beat_header     = 2'h3
	} beat_t;

	// ==========================================================
	// Operating states
	typedef enum logic [3:0] {
		ST_WAIT      = 4'h0,
		ST_SEL       = 4'h1,
		ST_GATE      = 4'h3,
		ST_DNLOAD    = 4'h2,
		ST_UPLOAD    = 4'h5,
		ST_DONE_UP   = 4'h7,
		ST_FAIL      = 4'h6,
		ST_ERASE     = 4'hC,
		ST_ERASE_ACK = 4'hD,
		ST_ERASE_OK  = 4'hF
	} state_t;

endpackage : app_key_pkg

`default_nettype wire

// ==== logic/app_store.sv ====
// Application store with registered read data.
`default_nettype none

module app_store #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 1024
) (
	// Clock
	input  wire logic                     clock,
	// Write port
	input  wire logic                     wr_en,
	input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
	input  wire logic [WIDTH-1:0]         wr_data,
	// Read port
	input  wire logic                     rd_en,
	input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
	output logic      [WIDTH-1:0]         rd_data_q
);

	logic [WIDTH-1:0] mem [DEPTH];

	if (DEPTH < 2 || WIDTH < 1) begin : g_bad_shape
		$error("app_store: DEPTH must be at least 2 and WIDTH at least 1");
	end

	always_ff @(posedge clock) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clock) begin
		if (rd_en) begin
			rd_data_q <= mem[rd_addr];
		end
	end

endmodule : app_store

`default_nettype wire

// ==== logic/word_fifo.sv ====
// Synchronous FIFO with valid and ready on both sides.
`default_nettype none

module word_fifo #(
	parameter int unsigned WIDTH = 9,
	parameter int unsigned DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             rst,
	// Filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] buf_q [DEPTH];
	logic [AW:0]      wr_q;
	logic [AW:0]      rd_q;

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("word_fifo: DEPTH must be a power of two of at least 2");
	end

	assign out_valid = (wr_q != rd_q);
	assign in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
	assign out_data  = buf_q[rd_q[AW-1:0]];

	always_ff @(posedge clock) begin
		if (in_valid && in_ready) begin
			buf_q[wr_q[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (in_valid && in_ready) begin
				wr_q <= wr_q + 1'b1;
			end
			if (out_valid && out_ready) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end

endmodule : word_fifo

`default_nettype wire

// ==== logic/app_key_transfer_control.sv ====
// Button, indicator and transfer control of the portable application key.
//
// Overview of operation
// (RULE1) After power-up both LEDs blink alternately while waiting for a selection.
// (RULE2) Each short press toggles upload/download; the selected LED blinks fast. The code's first short press from an idle state selects upload instead.
// (RULE3) A hold longer than 3 s starts the selected operation.
// (RULE4) Upload into the key blinks an LED, then green stays lit on success.
// (RULE5) Download blinks yellow; success returns to alternate blinking and starts the controller.
// (RULE6) Any failed upload or download blinks both LEDs together in phase.
// (RULE7) A hold longer than 15 s starts an erase of the key memory.
// (RULE8) Erase blinks green slowly, alternates twice, then leaves green steady.
// (RULE9) A failed erase blinks both LEDs together and may be retried.
// (RULE10) Uploads ignore protection tags and the store is never read back raw.
// (RULE11) Open application installs on open controllers, refused on customer-locked ones.
// (RULE12) Customer application installs on customer controller only with equal IDs.
// (RULE13) Customer application on open controller succeeds and the controller adopts its ID.
// (RULE14) Protection mismatch refuses the download with error code 51.
// (RULE15) Upload into an already loaded key fails with error code 52.
// (RULE16) Download from an empty key fails with error code 53.
// (RULE17) After a failed upload the operator must erase before uploading again; the code requires this only when the failed upload took a beat.
// (RULE18) Live parameter values are dropped; only design-time defaults are stored.
// (RULE19) A press released before 3 s only toggles and starts nothing.
`default_nettype none

`include "app_key_defs.svh"

module app_key_transfer_control #(
	parameter int unsigned WIDTH          = `KEY_DATA_WIDTH,
	parameter int unsigned DEPTH          = `KEY_STORE_DEPTH,
	parameter int unsigned FIFO_DEPTH     = `KEY_FIFO_DEPTH,
	parameter int unsigned CONFIRM_CYCLES = `KEY_CONFIRM_HOLD_MS * `KEY_CYC_PER_MS,
	parameter int unsigned ERASE_CYCLES   = `KEY_ERASE_HOLD_MS * `KEY_CYC_PER_MS,
	parameter int unsigned BLINK_CYCLES   = `KEY_BLINK_HALF_MS * `KEY_CYC_PER_MS
) (
	// Clock and reset
	input  wire logic                   clock,
	input  wire logic                   rst,
	// Operator button and indicators
	input  wire logic                   btn_pressed,
	output logic                        led_green_q,
	output logic                        led_yellow_q,
	// Upload stream from the link
	input  wire logic                   rx_valid,
	output logic                        rx_ready,
	input  wire logic [WIDTH-1:0]       rx_data,
	input  wire app_key_pkg::beat_t     rx_class,
	input  wire logic                   rx_last,
	input  wire logic                   link_fault,
	// Download stream to the controller
	output logic                        tx_valid,
	input  wire logic                   tx_ready,
	output logic      [WIDTH-1:0]       tx_data,
	output logic                        tx_last,
	// Controller protection handshake
	input  wire logic                   ctl_tag_valid,
	input  wire app_key_pkg::tag_kind_t ctl_tag_kind,
	input  wire logic [WIDTH-1:0]       ctl_customer_id,
	output logic                        adopt_valid_q,
	output logic      [WIDTH-1:0]       adopt_id_q,
	output logic                        run_start_q,
	// Error report for the controller display
	output logic                        err_valid_q,
	output logic      [7:0]             err_code_q,
	// Flash status
	input  wire logic                   flash_fault
);

	import app_key_pkg::*;

	localparam int unsigned AW = $clog2(DEPTH);

	if (CONFIRM_CYCLES < 1 || ERASE_CYCLES <= CONFIRM_CYCLES || BLINK_CYCLES < 1 || DEPTH < 2) begin : g_bad
		$error("app_key_transfer_control: hold and blink counts or DEPTH out of range");
	end

	// ==========================================================
	// State and storage bookkeeping
	state_t          st_q;
	state_t          st_d;
	logic            sel_dl_q;
	logic            loaded_q;
	tag_kind_t       app_kind_q;
	logic [WIDTH-1:0] app_id_q;
	logic            hdr_kind_seen_q;
	logic [AW:0]     app_len_q;
	logic [AW-1:0]   er_addr_q;
	logic [3:0]      ack_q;

	// ==========================================================
	// Button timing
	logic [31:0]     hold_q;
	logic            btn_prev_q;
	logic            released;
	logic            short_rel;
	logic            conf_rel;
	logic            erase_hit;
	logic            idle_like;

	assign released  = btn_prev_q && !btn_pressed;
	assign short_rel = released && (hold_q < CONFIRM_CYCLES);                            // see RULE19
	assign conf_rel  = released && (hold_q >= CONFIRM_CYCLES) && (hold_q < ERASE_CYCLES); // see RULE3
	assign erase_hit = btn_pressed && (hold_q == ERASE_CYCLES - 1);                        // see RULE7
	assign idle_like = (st_q == ST_WAIT) || (st_q == ST_DONE_UP) || (st_q == ST_FAIL) || (st_q == ST_ERASE_OK);

	always_ff @(posedge clock) begin
		if (rst) begin
			hold_q     <= 32'h0;
			btn_prev_q <= 1'b0;
		end else begin
			btn_prev_q <= btn_pressed;
			if (!btn_pressed) begin
				hold_q <= 32'h0;
			end else if (hold_q != 32'hFFFFFFFF) begin
				hold_q <= hold_q + 32'h1;
			end
		end
	end

	// ==========================================================
	// Blink time base: phase bit 0 is fast, 1 normal, 2 slow
	logic [31:0]     div_q;
	logic [2:0]      phase_q;
	logic            tick;

	assign tick = (div_q == BLINK_CYCLES - 1);

	always_ff @(posedge clock) begin
		if (rst) begin
			div_q   <= 32'h0;
			phase_q <= 3'h0;
		end else if (tick) begin
			div_q   <= 32'h0;
			phase_q <= phase_q + 3'h1;
		end else begin
			div_q <= div_q + 32'h1;
		end
	end

	// ==========================================================
	// Upload write path
	logic            up_beat;
	logic            up_store;
	logic            up_full;

	assign rx_ready = (st_q == ST_UPLOAD);
	assign up_beat  = rx_valid && rx_ready;
	// Live parameter beats are accepted and dropped so the link never stalls on them.
	assign up_store = up_beat && ((rx_class == beat_code) || (rx_class == beat_default)); // see RULE18
	assign up_full  = up_store && (app_len_q == DEPTH[AW:0]);

	// ==========================================================
	// Download read path and buffer
	logic [AW:0]     rd_addr_q;
	logic            rd_pend_q;
	logic            rd_last_q;
	logic            rd_issue;
	logic [WIDTH-1:0] store_rd;
	logic            fifo_in_ready;
	logic            fifo_out_valid;
	logic [WIDTH:0]  fifo_out;

	assign rd_issue = (st_q == ST_DNLOAD) && !rd_pend_q && fifo_in_ready && (rd_addr_q < app_len_q);
	assign tx_valid = fifo_out_valid && (st_q == ST_DNLOAD);
	assign tx_data  = fifo_out[WIDTH-1:0];
	assign tx_last  = fifo_out[WIDTH];

	always_ff @(posedge clock) begin
		if (rst || st_q != ST_DNLOAD) begin
			rd_addr_q <= '0;
			rd_pend_q <= 1'b0;
			rd_last_q <= 1'b0;
		end else begin
			rd_pend_q <= rd_issue;
			if (rd_issue) begin
				rd_addr_q <= rd_addr_q + 1'b1;
				rd_last_q <= (rd_addr_q + 1'b1 == app_len_q);
			end
		end
	end

	// The buffer is flushed outside a download so a refused or broken transfer leaves nothing behind.
	word_fifo #(
		.WIDTH (WIDTH + 1),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.clock     (clock),
		.rst       (rst || st_q != ST_DNLOAD),
		.in_valid  (rd_pend_q),
		.in_ready  (fifo_in_ready),
		.in_data   ({rd_last_q, store_rd}),
		.out_valid (fifo_out_valid),
		.out_ready (tx_ready),
		.out_data  (fifo_out)
	);

	// The store has no outward read port: its contents only leave through the gated download.
	app_store #(
		.WIDTH (WIDTH),
		.DEPTH (DEPTH)
	) u_store (
		.clock     (clock),
		.wr_en     ((up_store && !up_full) || (st_q == ST_ERASE)), // see RULE10
		.wr_addr   ((st_q == ST_ERASE) ? er_addr_q : app_len_q[AW-1:0]),
		.wr_data   ((st_q == ST_ERASE) ? {WIDTH{1'b0}} : rx_data),
		.rd_en     (rd_issue),
		.rd_addr   (rd_addr_q[AW-1:0]),
		.rd_data_q (store_rd)
	);

	// ==========================================================
	// Protection check of the stored application against the controller
	logic            id_allowed;
	logic            id_adopt;

	always_comb begin
		id_allowed = 1'b0;
		id_adopt   = 1'b0;
		case (app_kind_q)
			open_protection_tag: begin
				id_allowed = (ctl_tag_kind == open_protection_tag);                          // see RULE11
			end
			customer_locked_tag: begin
				if (ctl_tag_kind == open_protection_tag) begin
					id_allowed = 1'b1;                                                       // see RULE13
					id_adopt   = 1'b1;
				end else if (ctl_tag_kind == customer_locked_tag) begin
					id_allowed = (ctl_customer_id == app_id_q);                              // see RULE12
				end
			end
			sales_sample_tag: begin
				id_allowed = (ctl_tag_kind == open_protection_tag) || (ctl_tag_kind == sales_sample_tag);
			end
			default: begin
				id_allowed = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// Operation sequencing
	logic            err_fire;
	logic [7:0]      err_d;

	always_comb begin
		st_d     = st_q;
		err_fire = 1'b0;
		err_d    = `KEY_ERR_NONE;
		case (st_q)
			ST_WAIT, ST_DONE_UP, ST_FAIL, ST_ERASE_OK: begin
				if (erase_hit) begin
					st_d = ST_ERASE;                                                         // see RULE9
				end else if (short_rel) begin
					st_d = ST_SEL;
				end
			end
			ST_SEL: begin
				if (erase_hit) begin
					st_d = ST_ERASE;
				end else if (conf_rel && !sel_dl_q) begin
					if (loaded_q) begin
						st_d     = ST_FAIL;                                                  // see RULE15
						err_fire = 1'b1;
						err_d    = `KEY_ERR_MEM_FULL;
					end else begin
						st_d = ST_UPLOAD;
					end
				end else if (conf_rel && sel_dl_q) begin
					if (!loaded_q) begin
						st_d     = ST_FAIL;                                                  // see RULE16
						err_fire = 1'b1;
						err_d    = `KEY_ERR_MEM_EMPTY;
					end else begin
						st_d = ST_GATE;
					end
				end
			end
			ST_UPLOAD: begin
				if (link_fault) begin
					st_d = ST_FAIL;                                                          // see RULE6
				end else if (up_full) begin
					st_d     = ST_FAIL;
					err_fire = 1'b1;
					err_d    = `KEY_ERR_MEM_FULL;
				end else if (up_beat && rx_last) begin
					st_d = ST_DONE_UP;                                                       // see RULE4
				end
			end
			ST_GATE: begin
				if (link_fault) begin
					st_d = ST_FAIL;
				end else if (ctl_tag_valid && id_allowed) begin
					st_d = ST_DNLOAD;
				end else if (ctl_tag_valid) begin
					st_d     = ST_FAIL;                                                      // see RULE14
					err_fire = 1'b1;
					err_d    = `KEY_ERR_ID_MISMATCH;
				end
			end
			ST_DNLOAD: begin
				if (link_fault) begin
					st_d = ST_FAIL;                                                          // see RULE6
				end else if (tx_valid && tx_ready && tx_last) begin
					st_d = ST_WAIT;                                                          // see RULE5
				end
			end
			ST_ERASE: begin
				if (flash_fault) begin
					st_d = ST_FAIL;                                                          // see RULE9
				end else if (er_addr_q == AW'(DEPTH - 1)) begin
					st_d = ST_ERASE_ACK;
				end
			end
			ST_ERASE_ACK: begin
				if (ack_q == 4'(`KEY_ERASE_ACK_TICKS)) begin
					st_d = ST_ERASE_OK;                                                      // see RULE8
				end
			end
			default: begin
				st_d = ST_WAIT;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			st_q <= ST_WAIT;
		end else begin
			st_q <= st_d;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			sel_dl_q <= 1'b0;
		end else if (idle_like && short_rel) begin
			sel_dl_q <= 1'b0;
		end else if (st_q == ST_SEL && short_rel) begin
			sel_dl_q <= !sel_dl_q;                                                           // see RULE2
		end
	end

	// Any accepted upload beat marks the store as loaded, so a failed upload that took a beat is reopened only by an erase.
	always_ff @(posedge clock) begin
		if (rst) begin
			loaded_q        <= 1'b0;
			app_len_q       <= '0;
			app_kind_q      <= open_protection_tag;
			app_id_q        <= '0;
			hdr_kind_seen_q <= 1'b0;
		end else if (st_q == ST_ERASE) begin
			loaded_q        <= 1'b0;
			app_len_q       <= '0;
			app_kind_q      <= open_protection_tag;
			app_id_q        <= '0;
			hdr_kind_seen_q <= 1'b0;
		end else if (up_beat) begin
			loaded_q <= 1'b1;                                                                // see RULE17
			if (rx_class == beat_header && !hdr_kind_seen_q) begin
				app_kind_q      <= tag_kind_t'(rx_data[`KEY_TAG_WIDTH-1:0]);                 // see RULE10
				hdr_kind_seen_q <= 1'b1;
			end else if (rx_class == beat_header) begin
				app_id_q <= rx_data;
			end
			if (up_store && !up_full) begin
				app_len_q <= app_len_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst || st_q != ST_ERASE) begin
			er_addr_q <= '0;
		end else begin
			er_addr_q <= er_addr_q + 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst || st_q != ST_ERASE_ACK) begin
			ack_q <= 4'h0;
		end else if (tick) begin
			ack_q <= ack_q + 4'h1;
		end
	end

	// ==========================================================
	// Controller-facing pulses
	always_ff @(posedge clock) begin
		if (rst) begin
			err_valid_q   <= 1'b0;
			err_code_q    <= `KEY_ERR_NONE;
			adopt_valid_q <= 1'b0;
			adopt_id_q    <= '0;
			run_start_q   <= 1'b0;
		end else begin
			err_valid_q   <= err_fire;
			adopt_valid_q <= (st_q == ST_GATE) && ctl_tag_valid && id_allowed && id_adopt && !link_fault;
			run_start_q   <= (st_q == ST_DNLOAD) && (st_d == ST_WAIT);                       // see RULE5
			if (err_fire) begin
				err_code_q <= err_d;
			end
			if ((st_q == ST_GATE) && id_adopt) begin
				adopt_id_q <= app_id_q;                                                      // see RULE13
			end
		end
	end

	// ==========================================================
	// Indicator patterns
	always_ff @(posedge clock) begin
		if (rst) begin
			led_green_q  <= 1'b0;
			led_yellow_q <= 1'b0;
		end else begin
			case (st_q)
				ST_WAIT, ST_ERASE_ACK: begin
					led_green_q  <= phase_q[1];                                              // see RULE1
					led_yellow_q <= !phase_q[1];
				end
				ST_SEL: begin
					led_green_q  <= !sel_dl_q && phase_q[0];                                 // see RULE2
					led_yellow_q <= sel_dl_q && phase_q[0];
				end
				ST_UPLOAD: begin
					led_green_q  <= phase_q[1];                                              // see RULE4
					led_yellow_q <= 1'b0;
				end
				ST_GATE, ST_DNLOAD: begin
					led_green_q  <= 1'b0;
					led_yellow_q <= phase_q[1];                                              // see RULE5
				end
				ST_FAIL: begin
					led_green_q  <= phase_q[1];                                              // see RULE6
					led_yellow_q <= phase_q[1];
				end
				ST_ERASE: begin
					led_green_q  <= phase_q[2];                                              // see RULE8
					led_yellow_q <= 1'b0;
				end
				ST_DONE_UP, ST_ERASE_OK: begin
					led_green_q  <= 1'b1;
					led_yellow_q <= 1'b0;
				end
				default: begin
					led_green_q  <= 1'b0;
					led_yellow_q <= 1'b0;
				end
			endcase
		end
	end

endmodule : app_key_transfer_control

`default_nettype wire

// ==== dv/app_key_checker.sv ====
// Port-level checker of the key transfer control.
`default_nettype none
module app_key_checker #(
	parameter int unsigned WIDTH = 8
) (
	// Clock and reset
	input wire logic             clock,
	input wire logic             rst,
	// Streams and results
	input wire logic             rx_valid,
	input wire logic             rx_ready,
	input wire logic             rx_last,
	input wire logic             link_fault,
	input wire logic             tx_valid,
	input wire logic             tx_ready,
	input wire logic [WIDTH-1:0] tx_data,
	input wire logic             tx_last,
	input wire logic             adopt_valid_q,
	input wire logic             run_start_q,
	input wire logic             err_valid_q,
	input wire logic [7:0]       err_code_q
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_last_take;
		tx_valid && tx_ready && tx_last && !link_fault;
	endsequence
	sequence s_last_beat;
		rx_valid && rx_ready && rx_last && !link_fault;
	endsequence
	chk_reset_idle: assert property ($past(rst) |-> !rx_ready && !tx_valid && err_code_q == 8'h00)
		else $error("outputs not idle after reset");
	chk_err_codes: assert property (err_valid_q |-> err_code_q inside {8'h33, 8'h34, 8'h35})
		else $error("unknown error code reported");
	chk_err_pulse: assert property (err_valid_q |=> !err_valid_q && $stable(err_code_q))
		else $error("error report not a single pulse");
	chk_adopt_pulse: assert property (adopt_valid_q |=> !adopt_valid_q)
		else $error("adopt request longer than one cycle");
	chk_run_start: assert property (s_last_take |=> run_start_q)
		else $error("controller not started after last word");
	chk_tx_hold: assert property (tx_valid && !tx_ready && !link_fault |=> tx_valid && $stable(tx_data) && $stable(tx_last))
		else $error("download word changed while stalled");
	chk_link_abort: assert property (link_fault |-> ##[1:2] !tx_valid && !rx_ready)
		else $error("link loss did not abort transfer");
	chk_upload_done: assert property (s_last_beat |=> !rx_ready)
		else $error("upload not closed after last beat");
	chk_stream_excl: assert property (rx_ready |-> !tx_valid)
		else $error("key sends while loading");
endmodule : app_key_checker
bind app_key_transfer_control app_key_checker #(.WIDTH(WIDTH)) u_chk (.clock(clock), .rst(rst),
	.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_last(rx_last), .link_fault(link_fault), .tx_valid(tx_valid),
	.tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last), .adopt_valid_q(adopt_valid_q),
	.run_start_q(run_start_q), .err_valid_q(err_valid_q), .err_code_q(err_code_q));
`default_nettype wire

// ==== dv/ctl_model.sv ====
// Controller-side model that takes download words after a stall.
`default_nettype none
module ctl_model (
	// Clock and frame clear
	input  wire logic       clock,
	input  wire logic       clr,
	// Download stream
	input  wire logic       tx_valid,
	output logic            tx_ready,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_last
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] words [16];
	int         n_got = 0;
	int         last_at = 0;
	int         wait_cnt = 0;
	// The long stall lets the buffer fill until it refuses; then only every other cycle is taken.
	assign tx_ready = wait_cnt >= 20 && wait_cnt[0];
	always @(posedge clock) begin
		if (clr) begin
			n_got <= 0;
			wait_cnt <= 0;
		end else begin
			wait_cnt <= tx_valid ? wait_cnt + 1 : 0;
			if (tx_valid && tx_ready) begin
				words[n_got[3:0]] <= tx_data;
				n_got <= n_got + 1;
				if (tx_last) last_at <= n_got;
			end
		end
	end
endmodule : ctl_model
`default_nettype wire

// ==== dv/tb_app_key_transfer_control.sv ====
// Self-checking bench of the key transfer control.
`default_nettype none
module tb_app_key_transfer_control;
	timeunit 1ns;
	timeprecision 1ns;
	import app_key_pkg::*;
	localparam int CONF = 20;
	localparam int ERAS = 100;
	typedef struct packed {
		tag_kind_t  at;
		logic [7:0] aid;
		tag_kind_t  ct;
		logic [7:0] cid;
		logic       ok;
		logic       adopt;
	} row_t;
	localparam row_t ROWS [6] = '{
		'{open_protection_tag, 8'h00, customer_locked_tag, 8'h05, 1'b0, 1'b0},
		'{customer_locked_tag, 8'h07, customer_locked_tag, 8'h09, 1'b0, 1'b0},
		'{customer_locked_tag, 8'h07, customer_locked_tag, 8'h07, 1'b1, 1'b0},
		'{customer_locked_tag, 8'h07, open_protection_tag, 8'h00, 1'b1, 1'b1},
		'{sales_sample_tag, 8'h02, sales_sample_tag, 8'h00, 1'b1, 1'b0},
		'{open_protection_tag, 8'h00, open_protection_tag, 8'h00, 1'b1, 1'b0}};
	logic       clock = 1'b0, rst = 1'b1, btn_pressed = 1'b0, rx_valid = 1'b0, rx_last = 1'b0, clr = 1'b0;
	logic       link_fault = 1'b0, flash_fault = 1'b0, ctl_tag_valid = 1'b0;
	logic [7:0] rx_data = 8'h00, ctl_customer_id = 8'h00, tx_data, adopt_id_q, err_code_q, adopt_seen;
	beat_t      rx_class = beat_code;
	tag_kind_t  ctl_tag_kind = open_protection_tag;
	logic       rx_ready, tx_valid, tx_ready, tx_last, led_green_q, led_yellow_q, adopt_valid_q, run_start_q, err_valid_q;
	int         error_cnt = 0, checks_done = 0, adopt_n = 0, a0, k;
	always #10 clock = ~clock;
	always @(posedge clock) if (adopt_valid_q === 1'b1) begin
		adopt_seen <= adopt_id_q;
		adopt_n <= adopt_n + 1;
	end
	app_key_transfer_control #(.DEPTH(16), .CONFIRM_CYCLES(CONF), .ERASE_CYCLES(ERAS), .BLINK_CYCLES(2)) uut (
		.clock(clock), .rst(rst), .btn_pressed(btn_pressed), .led_green_q(led_green_q), .led_yellow_q(led_yellow_q),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_class(rx_class), .rx_last(rx_last),
		.link_fault(link_fault), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last),
		.ctl_tag_valid(ctl_tag_valid), .ctl_tag_kind(ctl_tag_kind), .ctl_customer_id(ctl_customer_id),
		.adopt_valid_q(adopt_valid_q), .adopt_id_q(adopt_id_q), .run_start_q(run_start_q),
		.err_valid_q(err_valid_q), .err_code_q(err_code_q), .flash_fault(flash_fault));
	ctl_model partner (.clock(clock), .clr(clr), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
		.tx_last(tx_last));
	task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic step(int n);
		repeat (n) @(posedge clock);
		#2;
	endtask : step
	task automatic press(int n);
		btn_pressed = 1'b1;
		step(n);
		btn_pressed = 1'b0;
		step(3);
	endtask : press
	task automatic in_phase();
		for (int j = 0; j < 4; j++) begin
			check("in phase", {7'h00, led_green_q ^ led_yellow_q}, 8'h00);
			step(1);
		end
	endtask : in_phase
	task automatic send(beat_t c, logic [7:0] d, logic l);
		rx_valid = 1'b1;
		rx_class = c;
		rx_data = d;
		rx_last = l;
		for (k = 0; k < 50 && rx_ready !== 1'b1; k++) step(1);
		step(1);
	endtask : send
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	initial begin
		#400000;
		error_cnt++;
		wrap_up();
	end
	initial begin
		step(10);
		rst = 1'b0;
		step(2);
		check("alternate", {7'h00, led_green_q ^ led_yellow_q}, 8'h01);
		for (int r = 0; r < 6; r++) begin
			press(ERAS + 5);
			step(70);
			check("erase leds", {6'h00, led_green_q, led_yellow_q}, 8'h02);
			press(2);
			press(CONF + 2);
			send(beat_header, {6'h00, ROWS[r].at}, 1'b0);
			send(beat_header, ROWS[r].aid, 1'b0);
			for (int i = 0; i < 10; i++) begin
				if (i == 3) send(beat_live_param, 8'hEE, 1'b0);
				send(i == 4 ? beat_default : beat_code, 8'h10 + i[7:0], i == 9);
			end
			rx_valid = 1'b0;
			rx_last = 1'b0;
			step(3);
			check("upload leds", {6'h00, led_green_q, led_yellow_q}, 8'h02);
			a0 = adopt_n;
			ctl_tag_kind = ROWS[r].ct;
			ctl_customer_id = ROWS[r].cid;
			ctl_tag_valid = 1'b1;
			clr = 1'b1;
			press(2);
			press(2);
			clr = 1'b0;
			press(CONF + 2);
			ctl_tag_valid = 1'b0;
			step(120);
			check("words", partner.n_got[7:0], ROWS[r].ok ? 8'h0A : 8'h00);
			check("adopted", {7'h00, adopt_n != a0}, {7'h00, ROWS[r].adopt});
			if (ROWS[r].adopt) check("adopt id", adopt_seen, 8'h07);
			if (!ROWS[r].ok) check("refuse code", err_code_q, 8'h33);
			if (ROWS[r].ok) begin
				check("last", partner.last_at[7:0], 8'h09);
				check("done leds", {7'h00, led_green_q ^ led_yellow_q}, 8'h01);
				for (int i = 0; i < 10; i++) check("word", partner.words[i], 8'h10 + i[7:0]);
			end
		end
		press(2);
		check("short press", {5'h00, led_yellow_q, rx_ready, tx_valid}, 8'h00);
		press(CONF + 2);
		check("full key", err_code_q, 8'h34);
		ctl_tag_valid = 1'b1;
		press(2);
		press(2);
		press(CONF + 2);
		ctl_tag_valid = 1'b0;
		step(25);
		link_fault = 1'b1;
		step(2);
		link_fault = 1'b0;
		check("aborted", {7'h00, tx_valid}, 8'h00);
		step(2);
		in_phase();
		flash_fault = 1'b1;
		press(ERAS + 5);
		flash_fault = 1'b0;
		step(3);
		in_phase();
		press(ERAS + 5);
		step(70);
		check("retry erase", {6'h00, led_green_q, led_yellow_q}, 8'h02);
		press(2);
		press(2);
		press(CONF + 2);
		check("empty key", err_code_q, 8'h35);
		wrap_up();
	end
endmodule : tb_app_key_transfer_control
`default_nettype wire
